// ---- hdl/rtc_pkg.sv ----
// Constants and carrier types shared by the timekeeping core.
package rtc_pkg;

    // Register addresses of the timekeeping window.
    localparam logic [4:0] ADDR_HSEC  = 5'h00;
    localparam logic [4:0] ADDR_SEC   = 5'h01;
    localparam logic [4:0] ADDR_MIN   = 5'h02;
    localparam logic [4:0] ADDR_HOUR  = 5'h03;
    localparam logic [4:0] ADDR_WDAY  = 5'h04;
    localparam logic [4:0] ADDR_DATE  = 5'h05;
    localparam logic [4:0] ADDR_MONTH = 5'h06;
    localparam logic [4:0] ADDR_YEAR  = 5'h07;
    localparam logic [4:0] ADDR_CTRL  = 5'h08;
    localparam logic [4:0] ADDR_LAST  = 5'h1f;

    // Bit positions inside the registers.
    localparam int START_BIT  = 7;
    localparam int FMT12_BIT  = 6;
    localparam int PM_BIT     = 5;
    localparam int RUN_BIT    = 5;
    localparam int LPYR_BIT   = 5;
    localparam int EXTCLK_BIT = 3;

    // Timing.
    localparam int         CLK_HZ          = 10_000_000;
    localparam int         OSC_FAIL_US     = 100;
    localparam logic [10:0] OSC_FAIL_CYCLES = 11'(OSC_FAIL_US * (CLK_HZ / 1_000_000));
    localparam logic [5:0] RUN_EDGES       = 6'h20;
    localparam logic [2:0] SRC_DIV_LAST    = 3'h7;
    localparam logic [5:0] PULSE_LONG      = 6'h29;
    localparam logic [5:0] PULSE_SHORT     = 6'h28;
    localparam logic [4:0] LONG_RUNS       = 5'h18;

    // BCD limits.
    localparam logic [7:0] HSEC_MAX   = 8'h99;
    localparam logic [6:0] SEC_MAX    = 7'h59;
    localparam logic [6:0] MIN_MAX    = 7'h59;
    localparam logic [5:0] H24_MAX    = 6'h23;
    localparam logic [4:0] H12_ELEVEN = 5'h11;
    localparam logic [4:0] H12_TWELVE = 5'h12;
    localparam logic [4:0] H12_ONE    = 5'h01;
    localparam logic [2:0] WDAY_MAX   = 3'h7;
    localparam logic [2:0] WDAY_MIN   = 3'h1;
    localparam logic [5:0] DATE_MIN   = 6'h01;
    localparam logic [5:0] DATE_31    = 6'h31;
    localparam logic [5:0] DATE_30    = 6'h30;
    localparam logic [5:0] DATE_29    = 6'h29;
    localparam logic [5:0] DATE_28    = 6'h28;
    localparam logic [4:0] MONTH_FEB  = 5'h02;
    localparam logic [4:0] MONTH_MAX  = 5'h12;
    localparam logic [4:0] MONTH_MIN  = 5'h01;
    localparam logic [7:0] YEAR_MAX   = 8'h99;

    typedef struct packed {
        logic [7:0] hsec;
        logic [6:0] sec;
        logic [6:0] min;
        logic [5:0] hour;
        logic [2:0] wday;
        logic [5:0] date;
        logic [4:0] month;
        logic [7:0] year;
    } rtc_time_s;

    typedef struct packed {
        logic [1:0]  pin_sync;
        logic        pin_prev;
        logic [2:0]  div;
        logic [5:0]  edge_cnt;
        logic        running;
        logic [10:0] idle_cnt;
        logic [5:0]  pulse_cnt;
        logic [4:0]  long_cnt;
        rtc_time_s   live;
        rtc_time_s   snap;
        logic        start;
        logic        fmt12;
        logic [7:0]  ctrl;
        logic [4:0]  last_addr;
        logic [7:0]  rdata;
    } rtc_state_s;

    localparam rtc_state_s STATE_RST = '0;

endpackage

// ---- hdl/rtc_timekeeping_core.sv ----
// Timekeeping core: source select, oscillator monitor, BCD calendar and read buffers.
`timescale 1ns/1ns
module rtc_timekeeping_core
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       clock_input_pin,
    output logic            crystal_enable,
    output logic            external_clock_enable,
    output logic            oscillator_running,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic       reg_first,
    input  wire logic [4:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic [7:0]      reg_rdata
);

    rtc_pkg::rtc_state_s s_q;
    rtc_pkg::rtc_state_s s_d;
    rtc_pkg::rtc_time_s  rsrc;
    logic                src_on;
    logic                src_edge;
    logic                tick4k;
    logic                h_inc;
    logic                s_inc;
    logic                m_inc;
    logic                hr_inc;
    logic                d_inc;
    logic                mo_inc;
    logic                y_inc;
    logic                refresh;
    logic [5:0]          pulse_last;
    logic [5:0]          hr_next;

    function automatic logic [7:0] bcd_next(input logic [7:0] v);
        if (v[3:0] == 4'h9)
            bcd_next = {v[7:4] + 4'h1, 4'h0};
        else
            bcd_next = {v[7:4], v[3:0] + 4'h1};
    endfunction

    // Two digits cannot tell 2100, 2200 and 2300 apart, so every fourth year counts.
    function automatic logic leap(input logic [7:0] y);
        if (y[4])
            leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
        else
            leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    endfunction

    function automatic logic [5:0] date_max(input logic [4:0] m, input logic [7:0] y);
        if (m == rtc_pkg::MONTH_FEB)
            date_max = leap(y) ? rtc_pkg::DATE_29 : rtc_pkg::DATE_28;
        else if ((m == 5'h04) || (m == 5'h06) || (m == 5'h09) || (m == 5'h11))
            date_max = rtc_pkg::DATE_30;
        else
            date_max = rtc_pkg::DATE_31;
    endfunction

    always_comb
    begin
        s_d = s_q;
        h_inc = 1'b0;
        s_inc = 1'b0;
        m_inc = 1'b0;
        hr_inc = 1'b0;
        d_inc = 1'b0;
        mo_inc = 1'b0;
        y_inc = 1'b0;
        hr_next = s_q.live.hour;
        s_d.pin_sync = {s_q.pin_sync[0], clock_input_pin};
        s_d.pin_prev = s_q.pin_sync[1];

        // The pin is only honoured while one of the two sources is switched on.
        src_on = s_q.start | s_q.ctrl[rtc_pkg::EXTCLK_BIT];
        src_edge = src_on && s_q.pin_sync[1] && !s_q.pin_prev;

        if (src_edge)
        begin
            s_d.idle_cnt = '0;
            if (s_q.edge_cnt != rtc_pkg::RUN_EDGES)
                s_d.edge_cnt = s_q.edge_cnt + 6'h01;
            if (s_q.edge_cnt == rtc_pkg::RUN_EDGES - 6'h01)
                s_d.running = 1'b1;
        end
        else if (s_q.idle_cnt == rtc_pkg::OSC_FAIL_CYCLES)
        begin
            s_d.running = 1'b0;
            s_d.edge_cnt = '0;
        end
        else
        begin
            s_d.idle_cnt = s_q.idle_cnt + 11'h001;
        end

        if (src_edge)
            s_d.div = s_q.div + 3'h1;
        tick4k = src_edge && (s_q.div == rtc_pkg::SRC_DIV_LAST);

        // Every 25th step is one pulse short so that 25 steps span exactly 250 ms.
        pulse_last = (s_q.long_cnt == rtc_pkg::LONG_RUNS) ?
                     rtc_pkg::PULSE_SHORT - 6'h01 : rtc_pkg::PULSE_LONG - 6'h01;
        if (tick4k)
        begin
            if (s_q.pulse_cnt == pulse_last)
            begin
                h_inc = 1'b1;
                s_d.pulse_cnt = '0;
                s_d.long_cnt = (s_q.long_cnt == rtc_pkg::LONG_RUNS) ? 5'h00 :
                               s_q.long_cnt + 5'h01;
            end
            else
            begin
                s_d.pulse_cnt = s_q.pulse_cnt + 6'h01;
            end
        end

        if (h_inc)
        begin
            if (s_q.live.hsec == rtc_pkg::HSEC_MAX)
            begin
                s_d.live.hsec = 8'h00;
                s_inc = 1'b1;
            end
            else
            begin
                s_d.live.hsec = bcd_next(s_q.live.hsec);
            end
        end
        if (s_inc)
        begin
            if (s_q.live.sec == rtc_pkg::SEC_MAX)
            begin
                s_d.live.sec = 7'h00;
                m_inc = 1'b1;
            end
            else
            begin
                s_d.live.sec = 7'(bcd_next({1'b0, s_q.live.sec}));
            end
        end
        if (m_inc)
        begin
            if (s_q.live.min == rtc_pkg::MIN_MAX)
            begin
                s_d.live.min = 7'h00;
                hr_inc = 1'b1;
            end
            else
            begin
                s_d.live.min = 7'(bcd_next({1'b0, s_q.live.min}));
            end
        end

        // In 12-hour mode bit 5 is the half-day flag; 11 PM to 12 AM ends the day.
        if (s_q.fmt12)
        begin
            if (s_q.live.hour[4:0] == rtc_pkg::H12_ELEVEN)
                hr_next = {~s_q.live.hour[rtc_pkg::PM_BIT], rtc_pkg::H12_TWELVE};
            else if (s_q.live.hour[4:0] == rtc_pkg::H12_TWELVE)
                hr_next = {s_q.live.hour[rtc_pkg::PM_BIT], rtc_pkg::H12_ONE};
            else
                hr_next = {s_q.live.hour[rtc_pkg::PM_BIT],
                           5'(bcd_next({3'h0, s_q.live.hour[4:0]}))};
        end
        else if (s_q.live.hour == rtc_pkg::H24_MAX)
        begin
            hr_next = 6'h00;
        end
        else
        begin
            hr_next = 6'(bcd_next({2'h0, s_q.live.hour}));
        end
        if (hr_inc)
        begin
            s_d.live.hour = hr_next;
            if (s_q.fmt12)
                d_inc = (s_q.live.hour[4:0] == rtc_pkg::H12_ELEVEN)
                        && s_q.live.hour[rtc_pkg::PM_BIT];
            else
                d_inc = (s_q.live.hour == rtc_pkg::H24_MAX);
        end

        if (d_inc)
        begin
            s_d.live.wday = (s_q.live.wday == rtc_pkg::WDAY_MAX) ? rtc_pkg::WDAY_MIN :
                            s_q.live.wday + 3'h1;
            if (s_q.live.date == date_max(s_q.live.month, s_q.live.year))
            begin
                s_d.live.date = rtc_pkg::DATE_MIN;
                mo_inc = 1'b1;
            end
            else
            begin
                s_d.live.date = 6'(bcd_next({2'h0, s_q.live.date}));
            end
        end
        if (mo_inc)
        begin
            if (s_q.live.month == rtc_pkg::MONTH_MAX)
            begin
                s_d.live.month = rtc_pkg::MONTH_MIN;
                y_inc = 1'b1;
            end
            else
            begin
                s_d.live.month = 5'(bcd_next({3'h0, s_q.live.month}));
            end
        end
        if (y_inc)
            s_d.live.year = (s_q.live.year == rtc_pkg::YEAR_MAX) ? 8'h00 :
                            bcd_next(s_q.live.year);

        // A write wins over a carry landing in the same register on the same cycle.
        if (reg_wr)
        begin
            case (reg_addr)
                rtc_pkg::ADDR_HSEC:
                    s_d.live.hsec = reg_wdata;
                rtc_pkg::ADDR_SEC:
                begin
                    s_d.start = reg_wdata[rtc_pkg::START_BIT];
                    s_d.live.sec = reg_wdata[6:0];
                end
                rtc_pkg::ADDR_MIN:
                    s_d.live.min = reg_wdata[6:0];
                rtc_pkg::ADDR_HOUR:
                begin
                    s_d.fmt12 = reg_wdata[rtc_pkg::FMT12_BIT];
                    s_d.live.hour = reg_wdata[5:0];
                end
                rtc_pkg::ADDR_WDAY:
                    s_d.live.wday = reg_wdata[2:0];
                rtc_pkg::ADDR_DATE:
                    s_d.live.date = reg_wdata[5:0];
                rtc_pkg::ADDR_MONTH:
                    s_d.live.month = reg_wdata[4:0];
                rtc_pkg::ADDR_YEAR:
                    s_d.live.year = reg_wdata;
                rtc_pkg::ADDR_CTRL:
                    s_d.ctrl = reg_wdata;
                default:
                    s_d.ctrl = s_q.ctrl;
            endcase
        end

        // The word read on a refresh cycle comes from the counters being captured.
        refresh = reg_rd && (reg_first ||
                  ((reg_addr == 5'h00) && (s_q.last_addr == rtc_pkg::ADDR_LAST)));
        rsrc = refresh ? s_q.live : s_q.snap;
        if (refresh)
            s_d.snap = s_q.live;
        if (reg_rd)
        begin
            s_d.last_addr = reg_addr;
            case (reg_addr)
                rtc_pkg::ADDR_HSEC:  s_d.rdata = rsrc.hsec;
                rtc_pkg::ADDR_SEC:   s_d.rdata = {s_q.start, rsrc.sec};
                rtc_pkg::ADDR_MIN:   s_d.rdata = {1'b0, rsrc.min};
                rtc_pkg::ADDR_HOUR:  s_d.rdata = {1'b0, s_q.fmt12, rsrc.hour};
                rtc_pkg::ADDR_WDAY:  s_d.rdata = {2'h0, s_q.running, 2'h0, rsrc.wday};
                rtc_pkg::ADDR_DATE:  s_d.rdata = {2'h0, rsrc.date};
                rtc_pkg::ADDR_MONTH: s_d.rdata = {2'h0, leap(rsrc.year), rsrc.month};
                rtc_pkg::ADDR_YEAR:  s_d.rdata = rsrc.year;
                rtc_pkg::ADDR_CTRL:  s_d.rdata = s_q.ctrl;
                default:             s_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            s_q <= rtc_pkg::STATE_RST;
        else
            s_q <= s_d;
    end

    // The crystal amplifier is off whenever the external clock input is selected.
    assign crystal_enable        = s_q.start && !s_q.ctrl[rtc_pkg::EXTCLK_BIT];
    assign external_clock_enable = s_q.ctrl[rtc_pkg::EXTCLK_BIT];
    assign oscillator_running    = s_q.running;
    assign reg_rdata             = s_q.rdata;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_src_gated_off: assert property (!src_on |=> $stable(s_q.div))
        else $error("divider moved with both sources off");
    a_xtal_follows: assert property ($fell(s_q.start) && !s_q.ctrl[rtc_pkg::EXTCLK_BIT]
        |-> !crystal_enable)
        else $error("crystal still enabled after stop");
    a_run_sets_32: assert property ($rose(oscillator_running)
        |-> $past(s_q.edge_cnt) == 6'h1f && $past(src_edge))
        else $error("running flag set without 32 edges");
    a_run_clears_idle: assert property ($fell(oscillator_running)
        |-> $past(s_q.idle_cnt) == rtc_pkg::OSC_FAIL_CYCLES)
        else $error("running flag cleared before timeout");
    a_hsec_spacing: assert property (s_q.long_cnt <= 5'h18
        && s_q.pulse_cnt <= ((s_q.long_cnt == 5'h18) ? 6'h27 : 6'h28))
        else $error("hundredth step at wrong pulse count");
    a_sec_carry: assert property (h_inc && s_q.live.hsec == 8'h99 && !reg_wr
        |=> s_q.live.hsec == 8'h00 && $changed(s_q.live.sec))
        else $error("hundredths rollover lost its carry");
    a_midnight_24: assert property (d_inc && !s_q.fmt12 && !reg_wr |-> s_q.live.hour == 6'h23
        ##1 s_q.live.hour == 6'h00)
        else $error("24-hour day end wrong");
    a_wday_wrap: assert property (d_inc && s_q.live.wday == 3'h7 && !reg_wr
        |=> s_q.live.wday == 3'h1)
        else $error("weekday did not wrap to 1");
    a_feb_length: assert property (mo_inc && s_q.live.month == 5'h02
        |-> s_q.live.date == (leap(s_q.live.year) ? 6'h29 : 6'h28))
        else $error("february length wrong");
    a_new_year: assert property (mo_inc && s_q.live.month == 5'h12 && !reg_wr
        |=> s_q.live.month == 5'h01 && s_q.live.date == 6'h01)
        else $error("december did not return to 01/01");
    a_year_wrap: assert property (y_inc && s_q.live.year == 8'h99 && !reg_wr
        |=> s_q.live.year == 8'h00)
        else $error("year did not wrap to 00");
    a_snap_copy: assert property (reg_rd && reg_first |=> s_q.snap == $past(s_q.live))
        else $error("snapshot not taken at read start");
    a_run_ro: assert property (reg_wr && reg_addr == 5'h04 && !src_edge
        && s_q.idle_cnt != rtc_pkg::OSC_FAIL_CYCLES |=> $stable(oscillator_running))
        else $error("write changed running flag");

    c_osc_up:     cover property ($rose(oscillator_running));
    c_day_end:    cover property (d_inc);
    c_year_end:   cover property (mo_inc && s_q.live.month == 5'h12);
    c_wrap_read:  cover property (refresh && !reg_first);

endmodule // rtc_timekeeping_core

// ---- verification/rtc_timekeeping_core_bench.sv ----
// Self-checking bench for the timekeeping core, driving its pins and register port directly.
`timescale 1ns/1ns
module rtc_timekeeping_core_bench;
    logic       clk;
    logic       rst;
    logic       pin;
    logic       xtal_en;
    logic       ext_en;
    logic       running;
    logic       reg_wr;
    logic       reg_rd;
    logic       reg_first;
    logic [4:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    int         fail_count;
    int         n_tests;

    rtc_timekeeping_core u_dut
    (
        .clk                   (clk),
        .rst                   (rst),
        .clock_input_pin       (pin),
        .crystal_enable        (xtal_en),
        .external_clock_enable (ext_en),
        .oscillator_running    (running),
        .reg_wr                (reg_wr),
        .reg_rd                (reg_rd),
        .reg_first             (reg_first),
        .reg_addr              (reg_addr),
        .reg_wdata             (reg_wdata),
        .reg_rdata             (reg_rdata)
    );

    always #50 clk = ~clk;

    task automatic complete_run();
        $display("Checks made %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check1(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic reg_write(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
        @(negedge clk);
    endtask

    // Data is taken at the negative edge after the accepting edge, so it has settled.
    task automatic reg_read(input logic [4:0] a, input logic first, output logic [7:0] d);
        @(posedge clk);
        reg_rd    <= 1'b1;
        reg_first <= first;
        reg_addr  <= a;
        @(posedge clk);
        reg_rd    <= 1'b0;
        reg_first <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask

    // Each pin cycle is long enough for the two-stage synchroniser to see both levels.
    task automatic pin_cycles(input int n);
        repeat (n)
        begin
            @(posedge clk);
            pin <= 1'b1;
            repeat (3) @(posedge clk);
            pin <= 1'b0;
            repeat (2) @(posedge clk);
        end
        @(negedge clk);
    endtask

    task automatic hsec_step(output int edges, output logic [7:0] h);
        logic [7:0] h0;
        reg_read(rtc_pkg::ADDR_HSEC, 1'b1, h0);
        edges = 0;
        h = h0;
        while (h === h0 && edges < 400)
        begin
            pin_cycles(1);
            repeat (4) @(posedge clk);
            edges++;
            reg_read(rtc_pkg::ADDR_HSEC, 1'b1, h);
        end
        check1("hundredths stepped", 1'b1, h !== h0);
    endtask

    task automatic t_reset();
        logic [7:0] d;
        check1("crystal enable at reset", 1'b0, xtal_en);
        check1("running at reset", 1'b0, running);
        reg_read(rtc_pkg::ADDR_WDAY, 1'b1, d);
        check8("weekday register at reset", 8'h00, d);
        reg_write(5'h09, 8'hff);
        reg_read(5'h09, 1'b1, d);
        check8("unmapped register", 8'h00, d);
        $display("test reset done");
    endtask

    task automatic t_run();
        logic [7:0] d;
        reg_write(rtc_pkg::ADDR_SEC, 8'h80);
        check1("crystal on with start", 1'b1, xtal_en);
        check1("external off", 1'b0, ext_en);
        pin_cycles(31);
        check1("running after 31 cycles", 1'b0, running);
        pin_cycles(1);
        check1("running after 32 cycles", 1'b1, running);
        reg_read(rtc_pkg::ADDR_WDAY, 1'b1, d);
        check8("running bit read", 8'h20, d);
        reg_write(rtc_pkg::ADDR_WDAY, 8'h00);
        reg_read(rtc_pkg::ADDR_WDAY, 1'b1, d);
        check8("running bit write ignored", 8'h20, d);
        repeat (940) @(posedge clk);
        @(negedge clk);
        check1("running before timeout", 1'b1, running);
        repeat (100) @(posedge clk);
        @(negedge clk);
        check1("running after timeout", 1'b0, running);
        $display("test oscillator monitor done");
    endtask

    task automatic t_ext();
        logic [7:0] d;
        reg_write(rtc_pkg::ADDR_SEC, 8'h00);
        check1("crystal off without start", 1'b0, xtal_en);
        reg_write(rtc_pkg::ADDR_CTRL, 8'h08);
        check1("external enable set", 1'b1, ext_en);
        reg_read(rtc_pkg::ADDR_CTRL, 1'b1, d);
        check8("control readback", 8'h08, d);
        pin_cycles(32);
        check1("running on external clock", 1'b1, running);
        reg_write(rtc_pkg::ADDR_SEC, 8'h80);
        check1("crystal off with external", 1'b0, xtal_en);
        reg_write(rtc_pkg::ADDR_SEC, 8'h00);
        reg_write(rtc_pkg::ADDR_CTRL, 8'h00);
        check1("external enable clear", 1'b0, ext_en);
        repeat (1100) @(posedge clk);
        pin_cycles(40);
        check1("pin ignored with both clear", 1'b0, running);
        $display("test clock source done");
    endtask

    // Any interval is 41 or 40 ticks of eight source cycles each.
    task automatic t_hsec();
        int         e;
        logic [7:0] h;
        reg_write(rtc_pkg::ADDR_SEC, 8'h80);
        hsec_step(e, h);
        repeat (3)
        begin
            hsec_step(e, h);
            check1("hundredth interval", 1'b1, e == 328 || e == 320);
        end
        $display("test hundredths done");
    endtask

    task automatic t_snap();
        logic [7:0] h0;
        logic [7:0] h1;
        reg_read(rtc_pkg::ADDR_HSEC, 1'b1, h0);
        pin_cycles(400);
        reg_read(rtc_pkg::ADDR_HSEC, 1'b0, h1);
        check8("buffered hundredths held", h0, h1);
        reg_read(rtc_pkg::ADDR_LAST, 1'b0, h1);
        check8("last address reads zero", 8'h00, h1);
        reg_read(rtc_pkg::ADDR_HSEC, 1'b0, h1);
        check1("wrap refreshes buffers", 1'b1, h1 !== h0);
        $display("test read buffers done");
    endtask

    // Loads a time just before a rollover, lets one hundredth pass, then reads all in one burst.
    task automatic roll_case(input logic fmt, input rtc_pkg::rtc_time_s t0,
                             input rtc_pkg::rtc_time_s t1);
        logic [7:0] d;
        logic [7:0] exp [8];
        int         e;
        int         yr;
        reg_write(rtc_pkg::ADDR_SEC, 8'h00);
        d = 8'h20;
        e = 0;
        while (d[5] === 1'b1 && e < 20)
        begin
            repeat (100) @(posedge clk);
            reg_read(rtc_pkg::ADDR_WDAY, 1'b1, d);
            e++;
        end
        check1("running cleared before load", 1'b0, d[5]);
        reg_write(rtc_pkg::ADDR_HSEC, t0.hsec);
        reg_write(rtc_pkg::ADDR_MIN, {1'b0, t0.min});
        reg_write(rtc_pkg::ADDR_HOUR, {1'b0, fmt, t0.hour});
        reg_write(rtc_pkg::ADDR_WDAY, {5'h00, t0.wday});
        reg_write(rtc_pkg::ADDR_DATE, {2'b00, t0.date});
        reg_write(rtc_pkg::ADDR_MONTH, {3'b000, t0.month});
        reg_write(rtc_pkg::ADDR_YEAR, t0.year);
        reg_write(rtc_pkg::ADDR_SEC, {1'b1, t0.sec});
        hsec_step(e, d);
        yr = 10 * int'(t1.year[7:4]) + int'(t1.year[3:0]);
        exp = '{t1.hsec, {1'b1, t1.sec}, {1'b0, t1.min}, {1'b0, fmt, t1.hour},
                {5'h00, t1.wday}, {2'b00, t1.date}, {2'b00, yr % 4 == 0, t1.month}, t1.year};
        for (int i = 0; i < 8; i++)
        begin
            reg_read(5'(i), i == 0, d);
            if (i == 4)
                d[5] = 1'b0;
            check8($sformatf("time byte %0d", i), exp[i], d);
        end
    endtask

    task automatic t_roll();
        roll_case(1'b0, '{8'h99, 7'h59, 7'h59, 6'h23, 3'h7, 6'h31, 5'h12, 8'h99},
                  '{8'h00, 7'h00, 7'h00, 6'h00, 3'h1, 6'h01, 5'h01, 8'h00});
        roll_case(1'b1, '{8'h99, 7'h59, 7'h59, 6'h31, 3'h3, 6'h28, 5'h02, 8'h01},
                  '{8'h00, 7'h00, 7'h00, 6'h12, 3'h4, 6'h01, 5'h03, 8'h01});
        roll_case(1'b0, '{8'h99, 7'h59, 7'h59, 6'h23, 3'h1, 6'h28, 5'h02, 8'h04},
                  '{8'h00, 7'h00, 7'h00, 6'h00, 3'h2, 6'h29, 5'h02, 8'h04});
        roll_case(1'b0, '{8'h99, 7'h59, 7'h59, 6'h23, 3'h2, 6'h30, 5'h04, 8'h05},
                  '{8'h00, 7'h00, 7'h00, 6'h00, 3'h3, 6'h01, 5'h05, 8'h05});
        $display("test calendar rollover done");
    endtask

    // Expected run is near 40000 cycles; the limit leaves ample margin.
    initial
    begin
        repeat (90000) @(posedge clk);
        fail_count++;
        $display("[FAIL] watchdog expected finish seen timeout");
        complete_run();
    end

    initial
    begin
        clk        = 1'b0;
        rst        = 1'b1;
        pin        = 1'b0;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        reg_first  = 1'b0;
        reg_addr   = 5'h00;
        reg_wdata  = 8'h00;
        fail_count = 0;
        n_tests    = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        t_reset();
        t_run();
        t_ext();
        t_hsec();
        t_snap();
        t_roll();
        complete_run();
    end
endmodule // rtc_timekeeping_core_bench
